// ---- shared/stack_direct_pkg.sv ----
// Purpose: Shared types and constants for stack and direct-page address generation.
// Assumes: One 20 MHz clock; all request fields come from logic on that clock.
// Notes:   The bank byte of every generated address is constant zero.
package stack_direct_pkg;

  localparam logic [7:0]  BANK_ZERO       = 8'h00;
  localparam logic [7:0]  EMU_STACK_PAGE  = 8'h01;
  localparam logic [7:0]  ZERO_PAGE       = 8'h00;
  localparam logic [15:0] SP_RESET        = 16'h01FF;
  localparam logic [23:0] ADDR_RESET      = 24'h000000;
  localparam int          ADDR_LOW_MSB    = 15;
  localparam int          PAGE_MSB        = 15;
  localparam int          PAGE_LSB        = 8;

  // Which address path a request uses.
  typedef enum logic [1:0] {
    ACC_STACK,      // Push, pull, call and return traffic: S plus a delta.
    ACC_STACK_REL,  // Stack-relative operand: S plus operand plus byte number.
    ACC_DIRECT,     // Direct, direct X, direct Y data access.
    ACC_DIRECT_PTR  // Long-indirect direct or push-effective-indirect pointer fetch.
  } access_kind_t;

  typedef struct packed {
    logic           valid;
    access_kind_t   kind;
    logic           carry_past;  // Stack op allowed to leave the emulation stack page.
    logic [7:0]     operand;     // Direct or stack-relative offset byte.
    logic [15:0]    index;       // X or Y for indexed direct, else zero.
    logic [15:0]    stack_delta; // Two's complement offset from S for ACC_STACK.
    logic [1:0]     byte_num;    // Byte of a multi-byte access, 0 to 2.
  } addr_req_t;

  typedef struct packed {
    logic           write;
    logic [15:0]    value;
  } sp_write_t;

endpackage

// ---- core/stack_direct_address_gen.sv ----
// Purpose: Effective addresses for stack and direct-page modes on a 24-bit bus.
// Assumes: Sequencer, direct register and mode flag are on clk_i; no pin inputs.
// Notes:   One request per cycle; the address appears one cycle after the request.
`timescale 1ns/100ps

module stack_direct_address_gen
  import stack_direct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        emulation_i,
  input  wire logic [15:0] direct_reg_i,
  input  wire addr_req_t   req_i,
  input  wire sp_write_t   sp_write_i,
  output logic [23:0]      addr_o,
  output logic             addr_valid_o,
  output logic [15:0]      stack_pointer_o
);

  // Keeps the high byte of a page and replaces the low byte with a wrapped offset.
  function automatic logic [15:0] page_wrap(input logic [7:0] page, input logic [15:0] sum);
    page_wrap = {page, sum[7:0]};
  endfunction

  logic        emulation_q;
  logic [15:0] sp;
  logic [15:0] next_sp;
  logic [15:0] next_addr_low;

  wire logic [7:0]  direct_base_high_byte = direct_reg_i[PAGE_MSB:PAGE_LSB];
  wire logic [7:0]  direct_base_low_byte  = direct_reg_i[7:0];
  wire logic        emulation_entry       = emulation_i && !emulation_q;

  // All sums are 16 bits wide, so a carry out of bit 15 is simply dropped.
  wire logic [15:0] stack_sum     = sp + req_i.stack_delta;
  wire logic [15:0] stack_rel_sum = sp + {8'h00, req_i.operand} + {14'h0000, req_i.byte_num};
  wire logic [15:0] direct_sum    = direct_reg_i + {8'h00, req_i.operand} + req_i.index;
  wire logic [15:0] ptr_start     = direct_reg_i + {8'h00, req_i.operand};
  wire logic [15:0] ptr_sum       = ptr_start + {14'h0000, req_i.byte_num};
  // In paged emulation, only the pointer start wraps; later bytes carry upward.
  wire logic [15:0] ptr_paged     = page_wrap(direct_base_high_byte, ptr_start)
                                    + {14'h0000, req_i.byte_num};
  wire logic        direct_paged  = emulation_i && (direct_base_low_byte == 8'h00);

  wire logic [15:0] stack_addr  = (emulation_i && !req_i.carry_past)
                                  ? page_wrap(EMU_STACK_PAGE, stack_sum)
                                  : stack_sum;
  wire logic [15:0] direct_addr = direct_paged
                                  ? page_wrap(direct_base_high_byte, direct_sum)
                                  : direct_sum;
  wire logic [15:0] ptr_addr    = direct_paged ? ptr_paged : ptr_sum;

  always_comb begin
    unique case (req_i.kind)
      ACC_STACK:      next_addr_low = stack_addr;
      ACC_STACK_REL:  next_addr_low = stack_rel_sum;
      ACC_DIRECT:     next_addr_low = direct_addr;
      ACC_DIRECT_PTR: next_addr_low = ptr_addr;
    endcase
  end

  // A plain write of S in emulation still lands in the stack page.
  always_comb begin
    next_sp = sp;
    if (sp_write_i.write) begin
      next_sp = sp_write_i.value;
    end
    if (emulation_entry || (emulation_i && sp_write_i.write)) begin
      next_sp[PAGE_MSB:PAGE_LSB] = EMU_STACK_PAGE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      emulation_q <= 1'b1;
      sp          <= SP_RESET;
    end else begin
      emulation_q <= emulation_i;
      sp          <= next_sp;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_o       <= ADDR_RESET;
      addr_valid_o <= 1'b0;
    end else begin
      addr_valid_o <= req_i.valid;
      if (req_i.valid) begin
        addr_o <= {BANK_ZERO, next_addr_low};
      end
    end
  end

  assign stack_pointer_o = sp;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence emu_entered;
    !emulation_i ##1 emulation_i;
  endsequence

  sequence no_request;
    !req_i.valid;
  endsequence

  sequence ptr_request;
    req_i.valid && req_i.kind == ACC_DIRECT_PTR;
  endsequence

  sequence sp_write_in_emu;
    emulation_i && sp_write_i.write;
  endsequence

  AST_BANK_ZERO: assert property (
    addr_valid_o |-> addr_o[23:16] == BANK_ZERO
  ) else $error("Generated address left bank zero.");

  AST_NATIVE_STACK: assert property (
    req_i.valid && !emulation_i && req_i.kind == ACC_STACK
    |=> addr_o[ADDR_LOW_MSB:0] == $past(stack_sum)
  ) else $error("Native stack address is not S plus delta in bank zero.");

  AST_EMU_STACK_PAGE: assert property (
    req_i.valid && emulation_i && req_i.kind == ACC_STACK && !req_i.carry_past
    |=> addr_o[PAGE_MSB:PAGE_LSB] == EMU_STACK_PAGE && addr_o[7:0] == $past(stack_sum[7:0])
  ) else $error("Emulation stack access left the stack page.");

  AST_EMU_STACK_CARRY: assert property (
    req_i.valid && emulation_i && req_i.kind == ACC_STACK && req_i.carry_past
    |=> addr_o[ADDR_LOW_MSB:0] == $past(stack_sum)
  ) else $error("Carry-past stack access was wrapped.");

  AST_NATIVE_DIRECT: assert property (
    req_i.valid && !emulation_i && req_i.kind == ACC_DIRECT
    |=> addr_o[ADDR_LOW_MSB:0] == $past(direct_sum)
  ) else $error("Native direct address is not the full bank-zero sum.");

  AST_EMU_DIRECT_PAGE: assert property (
    req_i.valid && direct_paged && req_i.kind == ACC_DIRECT
    |=> addr_o[PAGE_MSB:PAGE_LSB] == $past(direct_base_high_byte)
  ) else $error("Paged emulation direct address left its page.");

  AST_EMU_ZERO_PAGE: assert property (
    req_i.valid && emulation_i && direct_reg_i == 16'h0000 && req_i.kind == ACC_DIRECT
    |=> addr_o[PAGE_MSB:PAGE_LSB] == ZERO_PAGE
  ) else $error("Emulation direct access with zero base left page zero.");

  AST_EMU_DIRECT_SPAN: assert property (
    req_i.valid && emulation_i && direct_base_low_byte != 8'h00 && req_i.kind == ACC_DIRECT
    |=> addr_o[ADDR_LOW_MSB:0] == $past(direct_sum)
  ) else $error("Unaligned emulation direct access was wrapped.");

  AST_PTR_CARRY: assert property (
    req_i.valid && direct_paged && req_i.kind == ACC_DIRECT_PTR
    |=> addr_o[ADDR_LOW_MSB:0]
        == $past({direct_base_high_byte, req_i.operand} + {14'h0000, req_i.byte_num})
  ) else $error("Pointer fetch did not carry into the next page.");

  AST_EMU_ENTRY_SP: assert property (
    emu_entered |=> stack_pointer_o[PAGE_MSB:PAGE_LSB] == EMU_STACK_PAGE
  ) else $error("Stack high byte not forced on emulation entry.");

  // The memory side counts one access per pulse; a stretched pulse would make it
  // repeat an access.
  AST_VALID_PULSE: assert property (
    req_i.valid |=> addr_valid_o
  ) else $error("Address valid missing after a request.");

  AST_VALID_DROP: assert property (
    no_request |=> !addr_valid_o
  ) else $error("Address valid asserted without a request.");

  // Holding the address between requests keeps the bus quiet on idle cycles.
  AST_ADDR_HOLD: assert property (
    no_request |=> $stable(addr_o)
  ) else $error("Address changed without a request.");

  AST_STACK_REL: assert property (
    req_i.valid && req_i.kind == ACC_STACK_REL
    |=> addr_o[ADDR_LOW_MSB:0]
        == $past(stack_pointer_o + {8'h00, req_i.operand} + {14'h0000, req_i.byte_num})
  ) else $error("Stack-relative address was wrapped or misformed.");

  AST_NATIVE_PTR: assert property (
    ptr_request ##0 !emulation_i
    |=> addr_o[ADDR_LOW_MSB:0]
        == $past(direct_reg_i + {8'h00, req_i.operand} + {14'h0000, req_i.byte_num})
  ) else $error("Native pointer fetch is not the full bank-zero sum.");

  AST_EMU_PTR_SPAN: assert property (
    ptr_request ##0 (emulation_i && direct_base_low_byte != 8'h00)
    |=> addr_o[ADDR_LOW_MSB:0]
        == $past(direct_reg_i + {8'h00, req_i.operand} + {14'h0000, req_i.byte_num})
  ) else $error("Unaligned emulation pointer fetch was wrapped.");

  // Entry only rewrites the high byte, so software must save it before switching.
  AST_EMU_ENTRY_LOW: assert property (
    emu_entered ##0 !sp_write_i.write
    |=> stack_pointer_o[7:0] == $past(stack_pointer_o[7:0])
  ) else $error("Emulation entry disturbed the stack low byte.");

  AST_EMU_SP_WRITE: assert property (
    sp_write_in_emu
    |=> stack_pointer_o == {EMU_STACK_PAGE, $past(sp_write_i.value[7:0])}
  ) else $error("Stack write in emulation left the stack page.");

  AST_NATIVE_SP_WRITE: assert property (
    !emulation_i && sp_write_i.write
    |=> stack_pointer_o == $past(sp_write_i.value)
  ) else $error("Native stack write did not store the full value.");

endmodule

// ---- verification/mem_partner.sv ----
// Purpose: Memory side of the address bus; flags any address outside bank zero.
// Assumes: Addresses are qualified by the one-cycle valid pulse.
// Notes:   It returns no data, because the block has no read path of its own.
`timescale 1ns/100ps
module mem_partner (
  input  wire logic        clk_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        strobe_i,
  output wire logic        bank_fault_o
);
  logic fault = 1'b0;
  always @(posedge clk_i) begin
    if (strobe_i && (addr_i[23:16] !== 8'h00)) begin
      fault <= 1'b1;
    end
  end
  assign bank_fault_o = fault;
endmodule

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for stack and direct-page address generation.
// Assumes: Inputs change 1 ns after the rising edge; answers come one cycle later.
// Notes:   Native cases run first, so that the later switch counts as a mode entry.
`timescale 1ns/100ps
module testbench;
  import stack_direct_pkg::*;
  logic        clk_i        = 1'b0;
  logic        rst_b_i      = 1'b0;
  logic        emulation_i  = 1'b0;
  logic [15:0] direct_reg_i = 16'h0000;
  addr_req_t   req_i        = '0;
  sp_write_t   sp_write_i   = '0;
  logic [23:0] addr_o;
  logic        addr_valid_o;
  logic [15:0] stack_pointer_o;
  logic        bank_fault;
  int          errors       = 0;
  int          cmp_count    = 0;
  always #25 clk_i = ~clk_i;
  stack_direct_address_gen i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .emulation_i(emulation_i),
    .direct_reg_i(direct_reg_i), .req_i(req_i), .sp_write_i(sp_write_i), .addr_o(addr_o),
    .addr_valid_o(addr_valid_o), .stack_pointer_o(stack_pointer_o));
  mem_partner i_mem (.clk_i(clk_i), .addr_i(addr_o), .strobe_i(addr_valid_o),
    .bank_fault_o(bank_fault));
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ask(input access_kind_t k, input logic cp, input logic [7:0] op,
    input logic [15:0] ix, input logic [15:0] dl, input logic [1:0] bn, input logic [23:0] exp);
    @(posedge clk_i) #1;
    req_i = '{1'b1, k, cp, op, ix, dl, bn};
    @(posedge clk_i) #1;
    req_i.valid = 1'b0;
    chk("addr_valid_o", 24'h000001, {23'h000000, addr_valid_o});
    chk("addr_o", exp, addr_o);
    @(posedge clk_i) #1;
    chk("addr_valid_o", 24'h000000, {23'h000000, addr_valid_o});
    chk("addr_o", exp, addr_o);
  endtask
  task automatic set_sp(input logic [15:0] v, input logic [15:0] exp);
    @(posedge clk_i) #1;
    sp_write_i = '{1'b1, v};
    @(posedge clk_i) #1;
    sp_write_i.write = 1'b0;
    chk("stack_pointer_o", {8'h00, exp}, {8'h00, stack_pointer_o});
  endtask
  task automatic t_native;
    set_sp(16'hFFFF, 16'hFFFF);
    ask(ACC_STACK, 1'b0, 8'h00, 16'h0000, 16'h0002, 2'h0, 24'h000001);
    ask(ACC_STACK_REL, 1'b0, 8'hFF, 16'h0000, 16'h0000, 2'h2, 24'h000100);
    direct_reg_i = 16'hFFF0;
    ask(ACC_DIRECT, 1'b0, 8'h10, 16'h0100, 16'h0000, 2'h0, 24'h000100);
    ask(ACC_DIRECT_PTR, 1'b0, 8'h0F, 16'h0000, 16'h0000, 2'h1, 24'h000000);
  endtask
  task automatic t_entry;
    set_sp(16'h3456, 16'h3456);
    emulation_i = 1'b1;
    @(posedge clk_i) #1;
    chk("stack_pointer_o", 24'h000156, {8'h00, stack_pointer_o});
    set_sp(16'h37FF, 16'h01FF);
  endtask
  task automatic t_emu_stack;
    ask(ACC_STACK, 1'b0, 8'h00, 16'h0000, 16'h0001, 2'h0, 24'h000100);
    ask(ACC_STACK, 1'b1, 8'h00, 16'h0000, 16'h0001, 2'h0, 24'h000200);
    ask(ACC_STACK_REL, 1'b0, 8'h02, 16'h0000, 16'h0000, 2'h1, 24'h000202);
  endtask
  task automatic t_emu_direct;
    direct_reg_i = 16'h0000;
    ask(ACC_DIRECT, 1'b0, 8'hFF, 16'h0005, 16'h0000, 2'h0, 24'h000004);
    ask(ACC_DIRECT_PTR, 1'b0, 8'hFF, 16'h0000, 16'h0000, 2'h1, 24'h000100);
    direct_reg_i = 16'h1200;
    ask(ACC_DIRECT, 1'b0, 8'hF0, 16'h0020, 16'h0000, 2'h0, 24'h001210);
    ask(ACC_DIRECT_PTR, 1'b0, 8'hFE, 16'h0000, 16'h0000, 2'h2, 24'h001300);
    direct_reg_i = 16'h1234;
    ask(ACC_DIRECT, 1'b0, 8'hF0, 16'h0000, 16'h0000, 2'h0, 24'h001324);
    ask(ACC_DIRECT_PTR, 1'b0, 8'hF0, 16'h0000, 16'h0000, 2'h2, 24'h001326);
  endtask
  task automatic t_reset;
    set_sp(16'h3420, 16'h0120);
    rst_b_i = 1'b0;
    @(posedge clk_i) #1;
    chk("stack_pointer_o", 24'h0001FF, {8'h00, stack_pointer_o});
    chk("addr_o", 24'h000000, addr_o);
    chk("addr_valid_o", 24'h000000, {23'h000000, addr_valid_o});
    rst_b_i = 1'b1;
    ask(ACC_STACK, 1'b0, 8'h00, 16'h0000, 16'hFFFF, 2'h0, 24'h0001FE);
  endtask
  task automatic final_report;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(2000 * 50);
    errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    t_native();
    t_entry();
    t_emu_stack();
    t_emu_direct();
    t_reset();
    chk("bank_fault", 24'h000000, {23'h000000, bank_fault});
    final_report();
  end
endmodule
